// *** inc/ltc_regs.svh ***
`ifndef LTC_REGS_SVH
`define LTC_REGS_SVH

// Register byte offsets
`define LTC_CTRL_OFS       12'h000
`define LTC_MASK_OFS       12'h004
`define LTC_VCXO_OFS       12'h008
`define LTC_STAT_OFS       12'h00c
`define LTC_ALARM_EN_OFS   12'h010
`define LTC_ALARM_OFS      12'h014

// Control register fields
`define LTC_CTRL_WAN       0
`define LTC_CTRL_LAN_SREF  1
`define LTC_CTRL_VCO_FRC   5
`define LTC_CTRL_SYSLPBK   6
`define LTC_CTRL_SE_FRC    7
`define LTC_CTRL_SE_VAL    8
`define LTC_CTRL_FORCE_LT  9
`define LTC_CTRL_LOS_OVR   10
`define LTC_CTRL_AUTO_LT   14

// Mask register fields
`define LTC_MASK_AIS       14
`define LTC_MASK_LOF       15

// VCXO register fields
`define LTC_VCXO_SOLE      1
`define LTC_VCXO_LOOP_N    2
`define LTC_VCXO_RATE      3
`define LTC_VCXO_REF_RATE  4

// Status register fields
`define LTC_STAT_LOS_PIN   0
`define LTC_STAT_SYNC_ERR  1
`define LTC_STAT_LTOK      2
`define LTC_STAT_ON_RX     3
`define LTC_STAT_LT_EN     4

// Reset values
`define LTC_CTRL_RST       32'h0000_0001
`define LTC_MASK_RST       32'h0000_0000
`define LTC_VCXO_RST       32'h0000_0004
`define LTC_ALARM_EN_RST   32'h0000_0000

// Sync error detector: deviation limit and measuring window
`define LTC_SYNC_PPM       500
`define LTC_SYNC_WINDOW    8192

`endif

// *** inc/ltc_pkg.sv ***
package ltc_pkg;

  // Reference switch sequencer, one-hot
  typedef enum logic [1:0] {
    LTC_SW_RUN  = 2'b01,
    LTC_SW_WAIT = 2'b10
  } ltc_sw_state_t;

  // Reference sources of the transmit PLL
  typedef enum logic [1:0] {
    LTC_SRC_SONET = 2'd0,
    LTC_SRC_XAUI  = 2'd1,
    LTC_SRC_VCXO  = 2'd2,
    LTC_SRC_RX    = 2'd3
  } ltc_src_t;

  // Receive-side defect levels from the framer and line interface
  typedef struct packed {
    logic ssm_change;
    logic line_alarm;
    logic frame_loss;
    logic los;
  } ltc_defects_t;

  // Alarm conditions in enable and latch order
  typedef struct packed {
    logic ssm_change;
    logic line_alarm;
    logic frame_loss;
    logic sync_error;
    logic los;
  } ltc_alarms_t;

endpackage

// *** design/ltc_line_timing.sv ***
// Functional notes
// - Mode decoded from force bit 9 and automatic bit 14 of control.
// - Both bits clear: WAN uses sonet or VCXO; LAN uses xaui or sonet.
// - Automatic, WAN only: recovered clock while valid, else local reference; VCXO while its loop is closed.
// - Force bit set: recovered clock, WAN and LAN; VCXO while the VCXO loop is closed.
// - After reset line timing is disabled; local reference only.
// - Recovered clock valid only when all qualifying conditions hold.
// - Condition: receive VCO not forced.
// - Condition: system loopback not selected.
// - Condition: loss of signal inactive or overridden; pin level readable.
// - Condition: sync error clear, or override force 0 with value 1.
// - Condition: frame loss clear or masked; latched copy readable.
// - Condition: line alarm clear or masked; latched copy readable.
// - Every defect mask resets off and is set independently.
// - Valid output high only when conditions valid and line timing enabled.
// - With the VCXO loop closed, valid low forces phase detector output to zero volts.
// - Five separate alarm enables, all clear after reset.
// - VCXO loop enable low makes VCXO the transmit PLL reference.
// - Phase detector compares VCXO with sonet or recovered; three-state.
// - Divide-by-3 on each detector input, enabled while its rate select is clear.
// - VCXO PLL path works in WAN mode only.
// - Sync error when recovered clock is off by over 500 ppm.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "ltc_regs.svh"

module ltc_line_timing
  import ltc_pkg::*;
#(
  parameter int SYNC_WINDOW = `LTC_SYNC_WINDOW,
  parameter int SYNC_PPM    = `LTC_SYNC_PPM
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         sonet_ref_clock_in,
  input  wire logic         xaui_ref_clock_in,
  input  wire logic         vcxo_clock_in,
  input  wire logic         rx_recovered_clock,
  input  wire ltc_defects_t rx_defects,
  output logic              tx_pll_ref,
  output logic              line_timing_valid_out,
  output logic              rx_sync_error_flag,
  output logic              alarm_status_interrupt,
  output logic              pd_up,
  output logic              pd_down,
  output logic              pd_oe_n
);

  localparam int CW = $clog2(SYNC_WINDOW + 1) + 1;
  // Allowed edge-count deviation over one window, rounded down
  localparam int SYNC_LIMIT = (SYNC_WINDOW * SYNC_PPM) / 1000000;

  if (SYNC_WINDOW < 16 || SYNC_PPM < 1 || SYNC_LIMIT < 1) begin : g_bad_cfg
    $error("ltc_line_timing: window too short for the ppm limit");
  end

  function automatic logic rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  function automatic logic [CW-1:0] absdiff(input logic [CW-1:0] a,
                                            input logic [CW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // Register file
  logic [31:0] ctrl_reg;
  logic [31:0] mask_reg;
  logic [31:0] vcxo_reg;
  logic [31:0] alarm_en_reg;
  ltc_alarms_t alarm_reg;
  ltc_alarms_t alarm_next;
  logic        frame_loss_latched;
  logic        line_alarm_latched;

  logic wr_acc, rd_acc, setup;
  assign setup  = psel & ~penable;
  assign pready = psel & penable;
  assign wr_acc = pready & pwrite;
  // Clear on the edge that takes prdata, so no event slips between
  assign rd_acc = setup & ~pwrite;

  logic [31:0] status_word;
  logic        addr_ok;
  logic [31:0] rd_mux;

  always_comb begin
    addr_ok = 1'b1;
    if (paddr == `LTC_CTRL_OFS) begin
      rd_mux = ctrl_reg;
    end else if (paddr == `LTC_MASK_OFS) begin
      rd_mux = mask_reg;
    end else if (paddr == `LTC_VCXO_OFS) begin
      rd_mux = vcxo_reg;
    end else if (paddr == `LTC_STAT_OFS) begin
      rd_mux = status_word;
    end else if (paddr == `LTC_ALARM_EN_OFS) begin
      rd_mux = alarm_en_reg;
    end else if (paddr == `LTC_ALARM_OFS) begin
      rd_mux = {27'h0, alarm_reg};
    end else begin
      rd_mux  = 32'h0;
      addr_ok = 1'b0;
    end
  end

  // Read data and error captured in the setup cycle, zero wait states
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= ~addr_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg     <= `LTC_CTRL_RST;
      mask_reg     <= `LTC_MASK_RST;
      vcxo_reg     <= `LTC_VCXO_RST;
      alarm_en_reg <= `LTC_ALARM_EN_RST;
    end else if (wr_acc) begin
      if (paddr == `LTC_CTRL_OFS) begin
        ctrl_reg <= pwdata & 32'h0000_47e3;
      end else if (paddr == `LTC_MASK_OFS) begin
        mask_reg <= pwdata & 32'h0000_c000;
      end else if (paddr == `LTC_VCXO_OFS) begin
        vcxo_reg <= pwdata & 32'h0000_001e;
      end else if (paddr == `LTC_ALARM_EN_OFS) begin
        alarm_en_reg <= pwdata & 32'h0000_001f;
      end
    end
  end

  // Decoded controls
  logic wan, force_lt, auto_lt, vcxo_sole, vcxo_loop;
  assign wan       = ctrl_reg[`LTC_CTRL_WAN];
  assign force_lt  = ctrl_reg[`LTC_CTRL_FORCE_LT];
  assign auto_lt   = ctrl_reg[`LTC_CTRL_AUTO_LT];
  assign vcxo_sole = vcxo_reg[`LTC_VCXO_SOLE];
  assign vcxo_loop = ~vcxo_reg[`LTC_VCXO_LOOP_N] & wan;

  // Sampled clocks and their previous levels
  logic sref_q, rx_q, vcxo_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sref_q <= 1'b0;
      rx_q   <= 1'b0;
      vcxo_q <= 1'b0;
    end else begin
      sref_q <= sonet_ref_clock_in;
      rx_q   <= rx_recovered_clock;
      vcxo_q <= vcxo_clock_in;
    end
  end

  // Frequency check of recovered against local reference
  logic          local_edge;
  logic          rx_edge;
  logic [CW-1:0] win_cnt;
  logic [CW-1:0] rx_cnt;
  logic          local_lvl;
  logic          local_q;
  assign local_lvl  = (wan & vcxo_sole) ? vcxo_clock_in : sonet_ref_clock_in;
  assign local_q    = (wan & vcxo_sole) ? vcxo_q : sref_q;
  assign local_edge = rise(local_q, local_lvl);
  assign rx_edge    = rise(rx_q, rx_recovered_clock);

  always_ff @(posedge mclk) begin
    if (reset) begin
      win_cnt            <= '0;
      rx_cnt             <= '0;
      rx_sync_error_flag <= 1'b0;
    end else if (local_edge &&
                 win_cnt == CW'(SYNC_WINDOW - 1)) begin
      // Window closed: flag above the limit, relock within it
      rx_sync_error_flag <= absdiff(rx_cnt + CW'(rx_edge),
                                    CW'(SYNC_WINDOW)) >
                            CW'(SYNC_LIMIT);
      win_cnt <= '0;
      rx_cnt  <= '0;
    end else begin
      win_cnt <= win_cnt + CW'(local_edge);
      rx_cnt  <= rx_cnt + CW'(rx_edge);
    end
  end

  // Qualification of the recovered clock
  logic los_ok, se_ok, lof_ok, ais_ok, rx_valid, lt_enabled;
  assign los_ok = ~rx_defects.los |
                  ctrl_reg[`LTC_CTRL_LOS_OVR];
  assign se_ok  = ~rx_sync_error_flag |
                  (~ctrl_reg[`LTC_CTRL_SE_FRC] &
                   ctrl_reg[`LTC_CTRL_SE_VAL]);
  assign lof_ok = ~rx_defects.frame_loss | mask_reg[`LTC_MASK_LOF];
  assign ais_ok = ~rx_defects.line_alarm | mask_reg[`LTC_MASK_AIS];
  assign rx_valid = ~ctrl_reg[`LTC_CTRL_VCO_FRC] &
                    ~ctrl_reg[`LTC_CTRL_SYSLPBK] &
                    los_ok & se_ok & lof_ok & ais_ok;
  assign lt_enabled = force_lt | (auto_lt & wan);

  always_ff @(posedge mclk) begin
    if (reset) begin
      line_timing_valid_out <= 1'b0;
    end else begin
      line_timing_valid_out <= rx_valid & lt_enabled;
    end
  end

  // Source choice
  ltc_src_t want_src;
  ltc_src_t local_src;
  always_comb begin
    if (wan) begin
      local_src = (vcxo_sole | vcxo_loop) ? LTC_SRC_VCXO
                                          : LTC_SRC_SONET;
    end else begin
      local_src = ctrl_reg[`LTC_CTRL_LAN_SREF] ? LTC_SRC_SONET
                                               : LTC_SRC_XAUI;
    end
    if (force_lt) begin
      want_src = LTC_SRC_RX;
    end else if (auto_lt && wan && rx_valid) begin
      want_src = LTC_SRC_RX;
    end else begin
      want_src = local_src;
    end
    // With the VCXO loop closed the VCXO stays the PLL reference
    if (vcxo_loop && want_src == LTC_SRC_RX) begin
      want_src = LTC_SRC_VCXO;
    end
  end

  function automatic logic src_level(input ltc_src_t s,
                                     input logic [3:0] lv);
    return lv[s];
  endfunction

  logic [3:0] levels;
  assign levels = {rx_recovered_clock, vcxo_clock_in,
                   xaui_ref_clock_in, sonet_ref_clock_in};

  // Leave the old source while it is low, then take the new one while it is low, so no
  // shortened high pulse reaches the PLL
  ltc_sw_state_t sw_state;
  ltc_src_t      cur_src;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_state <= LTC_SW_RUN;
      cur_src  <= LTC_SRC_SONET;
    end else begin
      case (sw_state)
        LTC_SW_RUN: begin
          if (want_src != cur_src && !src_level(cur_src, levels)) begin
            sw_state <= LTC_SW_WAIT;
          end
        end
        LTC_SW_WAIT: begin
          if (!src_level(want_src, levels)) begin
            cur_src  <= want_src;
            sw_state <= LTC_SW_RUN;
          end
        end
        default: sw_state <= LTC_SW_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_pll_ref <= 1'b0;
    end else begin
      tx_pll_ref <= (sw_state == LTC_SW_RUN) &
                    src_level(cur_src, levels);
    end
  end

  // Phase detector with selectable divide-by-3 inputs
  logic [1:0] ref_div, vco_div;
  logic       pd_ref_lvl, pd_ref_q, pd_ref_edge, pd_vco_edge;
  logic       ref_tick, vco_tick;
  logic       pd_use_rx;
  assign pd_use_rx   = lt_enabled & rx_valid;
  assign pd_ref_lvl  = pd_use_rx ? rx_recovered_clock : sonet_ref_clock_in;
  assign pd_ref_q    = pd_use_rx ? rx_q : sref_q;
  assign pd_ref_edge = rise(pd_ref_q, pd_ref_lvl);
  assign pd_vco_edge = rise(vcxo_q, vcxo_clock_in);
  // Rate select clear means a fast input that needs dividing
  assign ref_tick = pd_ref_edge &
                    (vcxo_reg[`LTC_VCXO_REF_RATE] | ref_div == 2'd2);
  assign vco_tick = pd_vco_edge &
                    (vcxo_reg[`LTC_VCXO_RATE] | vco_div == 2'd2);

  always_ff @(posedge mclk) begin
    if (reset) begin
      ref_div <= 2'd0;
      vco_div <= 2'd0;
    end else begin
      if (pd_ref_edge) begin
        ref_div <= (ref_div == 2'd2) ? 2'd0 : ref_div + 2'd1;
      end
      if (pd_vco_edge) begin
        vco_div <= (vco_div == 2'd2) ? 2'd0 : vco_div + 2'd1;
      end
    end
  end

  logic up_reg, dn_reg;
  always_ff @(posedge mclk) begin
    if (reset || !vcxo_loop) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      // Both pending cancel, as in a classic reset-on-both detector
      up_reg <= (up_reg | ref_tick) & ~(dn_reg | vco_tick);
      dn_reg <= (dn_reg | vco_tick) & ~(up_reg | ref_tick);
    end
  end

  // Pump up drives high, down drives low, idle floats; loop off floats
  always_ff @(posedge mclk) begin
    if (reset || !vcxo_loop) begin
      pd_up   <= 1'b0;
      pd_down <= 1'b0;
      pd_oe_n <= 1'b1;
    end else if (!(rx_valid & lt_enabled)) begin
      pd_up   <= 1'b0;
      pd_down <= 1'b0;
      pd_oe_n <= 1'b0;
    end else begin
      pd_up   <= up_reg;
      pd_down <= dn_reg;
      pd_oe_n <= ~(up_reg | dn_reg);
    end
  end

  // Latched defects and alarms, cleared on read; a new event wins
  logic se_q;
  logic stat_rd, alarm_rd;
  assign stat_rd  = rd_acc & (paddr == `LTC_STAT_OFS);
  assign alarm_rd = rd_acc & (paddr == `LTC_ALARM_OFS);

  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_loss_latched <= 1'b0;
      line_alarm_latched <= 1'b0;
    end else begin
      frame_loss_latched <= rx_defects.frame_loss |
                            (frame_loss_latched & ~stat_rd);
      line_alarm_latched <= rx_defects.line_alarm |
                            (line_alarm_latched & ~stat_rd);
    end
  end

  // Sync error alarm on the rising edge of the flag, others on level
  assign alarm_next = {rx_defects.ssm_change, rx_defects.line_alarm,
                       rx_defects.frame_loss,
                       rx_sync_error_flag & ~se_q, rx_defects.los};

  always_ff @(posedge mclk) begin
    if (reset) begin
      se_q                   <= 1'b0;
      alarm_reg              <= '0;
      alarm_status_interrupt <= 1'b0;
    end else begin
      se_q                   <= rx_sync_error_flag;
      alarm_reg              <= alarm_next | (alarm_reg & {5{~alarm_rd}});
      alarm_status_interrupt <= |(alarm_reg & alarm_en_reg[4:0]);
    end
  end

  always_comb begin
    status_word                    = 32'h0;
    status_word[`LTC_STAT_LOS_PIN] = rx_defects.los;
    status_word[`LTC_STAT_SYNC_ERR] = rx_sync_error_flag;
    status_word[`LTC_STAT_LTOK]    = line_timing_valid_out;
    status_word[`LTC_STAT_ON_RX]   = (cur_src == LTC_SRC_RX);
    status_word[`LTC_STAT_LT_EN]   = lt_enabled;
    status_word[7]                 = frame_loss_latched;
    status_word[8]                 = line_alarm_latched;
  end

endmodule

// *** testbench/ltc_line_timing_asserts.sv ***
`timescale 1ns/100ps
`include "ltc_regs.svh"

module ltc_line_timing_chk
  import ltc_pkg::*;
#(
  parameter int SYNC_WINDOW = `LTC_SYNC_WINDOW,
  parameter int SYNC_PPM    = `LTC_SYNC_PPM
) (
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         sonet_ref_clock_in,
  input wire logic         xaui_ref_clock_in,
  input wire logic         vcxo_clock_in,
  input wire logic         rx_recovered_clock,
  input wire ltc_defects_t rx_defects,
  input wire logic         tx_pll_ref,
  input wire logic         line_timing_valid_out,
  input wire logic         rx_sync_error_flag,
  input wire logic         alarm_status_interrupt,
  input wire logic         pd_up,
  input wire logic         pd_down,
  input wire logic         pd_oe_n
);
  logic [31:0] ctrl_reg;
  logic [31:0] mask_reg;
  logic [31:0] vcxo_reg;
  logic [31:0] en_reg;
  logic        lt_ok;
  logic        pd_hold;

  // Shadow of the registers that feed the qualifying, detector and interrupt checks
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= `LTC_CTRL_RST;
      mask_reg <= `LTC_MASK_RST;
      vcxo_reg <= `LTC_VCXO_RST;
      en_reg   <= `LTC_ALARM_EN_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == `LTC_CTRL_OFS) ctrl_reg <= pwdata;
      if (paddr == `LTC_MASK_OFS) mask_reg <= pwdata;
      if (paddr == `LTC_VCXO_OFS) vcxo_reg <= pwdata;
      if (paddr == `LTC_ALARM_EN_OFS) en_reg <= pwdata;
    end
  end

  assign lt_ok = (ctrl_reg[9] | ctrl_reg[14] & ctrl_reg[0])
    & ~ctrl_reg[5] & ~ctrl_reg[6] & (~rx_defects.los | ctrl_reg[10])
    & (~rx_sync_error_flag | ~ctrl_reg[7] & ctrl_reg[8])
    & (~rx_defects.frame_loss | mask_reg[15])
    & (~rx_defects.line_alarm | mask_reg[14]);
  assign pd_hold = ~vcxo_reg[2] & ctrl_reg[0] & ~lt_ok;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_valid;
    line_timing_valid_out == $past(lt_ok);
  endproperty
  a_valid: assert property (p_valid)
    else $error("valid output disagrees with qualifying conditions");
  property p_vco;
    $past(ctrl_reg[5]) |-> !line_timing_valid_out;
  endproperty
  a_vco: assert property (p_vco)
    else $error("valid output high with receive VCO forced");
  property p_lpbk;
    $past(ctrl_reg[6]) |-> !line_timing_valid_out;
  endproperty
  a_lpbk: assert property (p_lpbk)
    else $error("valid output high in system loopback");
  property p_los;
    $past(rx_defects.los & ~ctrl_reg[10]) |-> !line_timing_valid_out;
  endproperty
  a_los: assert property (p_los)
    else $error("valid output high with unmasked loss of signal");
  property p_sync;
    $past(rx_sync_error_flag & (ctrl_reg[7] | ~ctrl_reg[8]))
      |-> !line_timing_valid_out;
  endproperty
  a_sync: assert property (p_sync)
    else $error("valid output high with sync error not overridden");
  property p_lof;
    $past(rx_defects.frame_loss & ~mask_reg[15]) |-> !line_timing_valid_out;
  endproperty
  a_lof: assert property (p_lof)
    else $error("valid output high with unmasked frame loss");
  property p_ais;
    $past(rx_defects.line_alarm & ~mask_reg[14]) |-> !line_timing_valid_out;
  endproperty
  a_ais: assert property (p_ais)
    else $error("valid output high with unmasked line alarm");
  property p_lan;
    $past(~ctrl_reg[0] & ~ctrl_reg[9]) |-> !line_timing_valid_out;
  endproperty
  a_lan: assert property (p_lan)
    else $error("automatic line timing accepted in LAN mode");
  property p_rst;
    @(posedge mclk) disable iff (1'b0)
      reset |=> !line_timing_valid_out && !tx_pll_ref && pd_oe_n
        && !alarm_status_interrupt && !rx_sync_error_flag;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not at rest after reset");
  property p_pd0;
    $past(pd_hold) && $past(pd_hold, 2) |-> !pd_up && !pd_down && !pd_oe_n;
  endproperty
  a_pd0: assert property (p_pd0)
    else $error("detector not held at zero while timing invalid");
  property p_pdoff;
    $past(vcxo_reg[2]) && $past(vcxo_reg[2], 2) |-> pd_oe_n;
  endproperty
  a_pdoff: assert property (p_pdoff)
    else $error("detector driving with VCXO loop off");
  property p_int;
    $past(en_reg[4:0] == 5'h00) && $past(en_reg[4:0] == 5'h00, 2)
      |-> !alarm_status_interrupt;
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt raised with every enable clear");
  property p_glitch;
    $rose(tx_pll_ref) |-> $past(sonet_ref_clock_in | xaui_ref_clock_in
      | vcxo_clock_in | rx_recovered_clock);
  endproperty
  a_glitch: assert property (p_glitch)
    else $error("reference edge without a source edge");

  c_valid: cover property (line_timing_valid_out);
  c_err: cover property (pslverr);
  c_sync: cover property (rx_sync_error_flag);
  c_pd: cover property (!pd_oe_n && pd_up);
endmodule

// *** testbench/ltc_far_end.sv ***
`timescale 1ns/100ps

module ltc_far_end (
  input  wire logic       mclk,
  input  wire logic [3:0] rx_half,
  output logic            sonet_clk,
  output logic            xaui_clk,
  output logic            vcxo_clk,
  output logic            rx_clk
);
  logic [3:0] ref_cnt = 4'h0;
  logic [3:0] rx_cnt  = 4'h0;
  logic       rx_q    = 1'b0;

  // Local oscillators run free at fixed fractions of mclk
  always_ff @(posedge mclk) begin
    ref_cnt <= ref_cnt + 4'h1;
  end
  assign sonet_clk = ref_cnt[1];
  assign vcxo_clk  = ref_cnt[2];
  assign xaui_clk  = ref_cnt[3];

  // Line rate set by the bench; off nominal it must raise sync error
  always_ff @(posedge mclk) begin
    if (rx_cnt >= rx_half - 4'h1) begin
      rx_cnt <= 4'h0;
      rx_q   <= ~rx_q;
    end else begin
      rx_cnt <= rx_cnt + 4'h1;
    end
  end
  assign rx_clk = rx_q;
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`include "ltc_regs.svh"

module tb_top;
  import ltc_pkg::*;
  typedef struct packed {
    logic [15:0]  c;
    logic [15:0]  m;
    ltc_defects_t d;
    logic         v;
  } ltc_row_t;
  logic         mclk    = 1'b0;
  logic         reset   = 1'b1;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [11:0]  paddr   = 12'h000;
  logic [31:0]  pwdata  = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         sref, xref, vref, rxc;
  logic [3:0]   rx_half = 4'h2;
  ltc_defects_t defects = '0;
  logic         tx_pll_ref, ltok, sync_flag, irq;
  logic         pd_up, pd_down, pd_oe_n;
  logic [31:0]  rd_q;
  logic         err_q;
  int           bad_count   = 0;
  int           checks_done = 0;
  int           k;
  ltc_row_t     rows [15] = '{
    '{16'h0001, 16'h0000, 4'h0, 1'b0},
    '{16'h4001, 16'h0000, 4'h0, 1'b1},
    '{16'h4000, 16'h0000, 4'h0, 1'b0},
    '{16'h0200, 16'h0000, 4'h0, 1'b1},
    '{16'h4201, 16'h0000, 4'h0, 1'b1},
    '{16'h4021, 16'h0000, 4'h0, 1'b0},
    '{16'h4041, 16'h0000, 4'h0, 1'b0},
    '{16'h4001, 16'h0000, 4'h1, 1'b0},
    '{16'h4401, 16'h0000, 4'h1, 1'b1},
    '{16'h4001, 16'h0000, 4'h2, 1'b0},
    '{16'h4001, 16'h8000, 4'h2, 1'b1},
    '{16'h4001, 16'h0000, 4'h4, 1'b0},
    '{16'h4001, 16'h4000, 4'h4, 1'b1},
    '{16'h4001, 16'h4000, 4'h2, 1'b0},
    '{16'h4001, 16'h0000, 4'h8, 1'b1}
  };

  always #2.5 mclk = ~mclk;

  ltc_far_end FAR (.mclk, .rx_half, .sonet_clk(sref), .xaui_clk(xref),
    .vcxo_clk(vref), .rx_clk(rxc));
  ltc_line_timing #(.SYNC_WINDOW(2048)) DUT (.mclk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sonet_ref_clock_in(sref), .xaui_ref_clock_in(xref),
    .vcxo_clock_in(vref), .rx_recovered_clock(rxc), .rx_defects(defects),
    .tx_pll_ref, .line_timing_valid_out(ltok),
    .rx_sync_error_flag(sync_flag), .alarm_status_interrupt(irq),
    .pd_up, .pd_down, .pd_oe_n);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Setup then access; held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q  = prdata;
    err_q = pslverr;
    if (n >= 50)
      check(n, 0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask

  // Rising edges of the selected reference over a fixed span
  task automatic count_ref(input int exp);
    logic prev;
    k = 0;
    repeat (20) @(posedge mclk);
    prev = tx_pll_ref;
    repeat (120) begin
      @(posedge mclk);
      if (tx_pll_ref === 1'b1 && prev === 1'b0)
        k++;
      prev = tx_pll_ref;
    end
    check(k, exp);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rdchk(`LTC_CTRL_OFS, 32'h1);
    rdchk(`LTC_MASK_OFS, 32'h0);
    rdchk(`LTC_VCXO_OFS, 32'h4);
    rdchk(`LTC_ALARM_EN_OFS, 32'h0);
    rdchk(12'h018, 32'h0);
    check(err_q, 1'b1);
    foreach (rows[i]) begin
      defects <= rows[i].d;
      wr(`LTC_CTRL_OFS, {16'h0, rows[i].c});
      wr(`LTC_MASK_OFS, {16'h0, rows[i].m});
      repeat (3) @(posedge mclk);
      check(ltok, rows[i].v);
      apb(1'b0, `LTC_STAT_OFS, 32'h0);
      check(rd_q[2], rows[i].v);
      check(rd_q[0], rows[i].d.los);
    end
    defects <= '0;
    apb(1'b0, `LTC_ALARM_OFS, 32'h0);
    wr(`LTC_ALARM_EN_OFS, 32'h02);
    defects.los <= 1'b1;
    repeat (3) @(posedge mclk);
    check(irq, 1'b0);
    wr(`LTC_ALARM_EN_OFS, 32'h01);
    repeat (3) @(posedge mclk);
    check(irq, 1'b1);
    defects <= '0;
    rdchk(`LTC_ALARM_OFS, 32'h01);
    repeat (3) @(posedge mclk);
    check(irq, 1'b0);
    defects.ssm_change <= 1'b1;
    @(posedge mclk);
    defects <= '0;
    rdchk(`LTC_ALARM_OFS, 32'h10);
    wr(`LTC_CTRL_OFS, 32'h1);
    wr(`LTC_VCXO_OFS, 32'h10);
    repeat (3) @(posedge mclk);
    check({pd_up, pd_down, pd_oe_n}, 3'b000);
    count_ref(15);
    wr(`LTC_CTRL_OFS, 32'h4001);
    k = 0;
    repeat (100) begin
      @(posedge mclk);
      if (pd_up === 1'b1 || pd_down === 1'b1)
        k = 1;
    end
    check(k, 1);
    wr(`LTC_VCXO_OFS, 32'h4);
    wr(`LTC_CTRL_OFS, 32'h1);
    count_ref(30);
    rx_half <= 4'h3;
    wr(`LTC_CTRL_OFS, 32'h0200);
    count_ref(20);
    k = 0;
    while (sync_flag !== 1'b1 && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    check(sync_flag, 1'b1);
    apb(1'b0, `LTC_STAT_OFS, 32'h0);
    check(rd_q[1], 1'b1);
    wr(`LTC_CTRL_OFS, 32'h4001);
    repeat (3) @(posedge mclk);
    check(ltok, 1'b0);
    count_ref(30);
    wr(`LTC_CTRL_OFS, 32'h4101);
    repeat (3) @(posedge mclk);
    check(ltok, 1'b1);
    count_ref(20);
    wr(`LTC_CTRL_OFS, 32'h4181);
    repeat (3) @(posedge mclk);
    check(ltok, 1'b0);
    wr(`LTC_VCXO_OFS, 32'h6);
    count_ref(15);
    // Second reset in mid-run must restore disabled line timing
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rdchk(`LTC_CTRL_OFS, 32'h1);
    check(ltok, 1'b0);
    give_verdict;
  end

  initial begin
    #(5 * 100000);
    bad_count++;
    give_verdict;
  end
endmodule

bind ltc_line_timing ltc_line_timing_chk #(.SYNC_WINDOW(SYNC_WINDOW),
  .SYNC_PPM(SYNC_PPM)) CHK (.mclk, .reset, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sonet_ref_clock_in,
  .xaui_ref_clock_in, .vcxo_clock_in, .rx_recovered_clock, .rx_defects,
  .tx_pll_ref, .line_timing_valid_out, .rx_sync_error_flag,
  .alarm_status_interrupt, .pd_up, .pd_down, .pd_oe_n);
